/* File: aic_cause_regs.sv */
// Per-axis error and event cause registers behind a Wishbone slave.
// Assumes the motion core gives one-cycle cause pulses on clk_i.
//
// What this block does
// - Error cause bit set on error; read only
// - Event cause bit set on event; read only
// - Clear mode 1: clear only by data write
// - Comparator 1-5 stops set error bits 0-4
// - End limits, alarm set error bits 5-7
// - Shared stop, emergency set error bits 8-9
// - Slow-down stop sets error bit 10
// - Interpolation data error sets error bit 12
// - Partner axis error stop sets bit 13
// - Pulser buffer overflow sets bit 14, stops
// - Position counter overrange sets bit 15, stops
// - Encoder/pulser input errors: bits 16-17, no stop
// - Linear 1 start on one axis: data error
// - Circular start on one axis: data error
// - Circular start with zero center: data error
// - Circular start on three/four axes: data error
// - Linear 2 start, zero step count: error
// - Fourth-axis synced circle failure: data error
// - Event bits 0-3: stop, next, pre-registers
// - Comparator 1-5 matches set event bits 8-12
// - Clear, latch, origin latch: event bits 13-15
// - Slow-down, pulsers, shared start: bits 16-19
`timescale 1ns/100ps
`include "aic_defines.svh"
`default_nettype none

module aic_cause_regs
  import aic_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`AIC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Error stop causes, one-cycle pulses
  input wire logic [4:0] err_cmp_stop_i,
  input wire logic err_pos_limit_i,
  input wire logic err_neg_limit_i,
  input wire logic err_alarm_i,
  input wire logic err_shared_stop_i,
  input wire logic err_emergency_i,
  input wire logic err_slowdown_stop_i,
  input wire logic err_partner_axis_stop_i,
  input wire logic err_pulser_overflow_i,
  input wire logic err_position_range_i,
  input wire logic err_encoder_input_i,
  input wire logic err_pulser_input_i,
  // Event causes, one-cycle pulses
  input wire logic ev_auto_stop_i,
  input wire logic ev_next_start_i,
  input wire logic ev_second_prereg_free_i,
  input wire logic ev_cmp5_prereg_free_i,
  input wire logic [4:0] ev_cmp_match_i,
  input wire logic ev_counter_cleared_i,
  input wire logic ev_counter_latched_i,
  input wire logic ev_origin_latched_i,
  input wire logic ev_slowdown_on_i,
  input wire logic ev_pos_pulser_change_i,
  input wire logic ev_neg_pulser_change_i,
  input wire logic ev_shared_start_i,
  // Interpolation start check
  input wire logic start_i,
  input wire logic [3:0] start_axes_i,
  input wire logic [7:0] operation_code_i,
  input wire logic circle_center_zero_i,
  input wire logic [31:0] interp_step_count_i,
  input wire logic fourth_axis_fail_i,
  // Results
  output logic irq_o,
  output logic stop_request_o,
  output logic cause_clear_mode_o
);

  // ==========================================
  // Operation code classification
  function automatic aic_op_class_t op_class(input logic [7:0] op);
    unique case (op)
      `AIC_OP_L1A, `AIC_OP_L1B, `AIC_OP_L1C, `AIC_OP_L1D: op_class = AIC_OPC_LIN1;
      `AIC_OP_L2A, `AIC_OP_L2B, `AIC_OP_L2C, `AIC_OP_L2D: op_class = AIC_OPC_LIN2;
      `AIC_OP_C0, `AIC_OP_C1, `AIC_OP_CS0, `AIC_OP_CS1,
      `AIC_OP_C2, `AIC_OP_C3: op_class = AIC_OPC_CIRC;
      default: op_class = AIC_OPC_NONE;
    endcase
  endfunction

  // ==========================================
  // Bus decode
  logic req; // Request not yet answered
  logic rd_err; // Read of error cause
  logic rd_ev; // Read of event cause
  logic wr_err; // Write to error cause
  logic [2:0] axes_n; // Number of started axes
  aic_op_class_t cls; // Class of the start code
  logic op_sync; // Circle synced to fourth axis
  logic interp_err; // Data error this cycle
  aic_word_t err_set; // Error causes this cycle
  aic_word_t ev_set; // Event causes this cycle

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_err = req & ~wb_we_i & (wb_adr_i == `AIC_OFF_ERR);
  assign rd_ev = req & ~wb_we_i & (wb_adr_i == `AIC_OFF_EV);
  assign wr_err = req & wb_we_i & (wb_adr_i == `AIC_OFF_ERR);
  assign axes_n = 3'(start_axes_i[0]) + 3'(start_axes_i[1])
                + 3'(start_axes_i[2]) + 3'(start_axes_i[3]);
  assign cls = op_class(operation_code_i);
  assign op_sync = (operation_code_i == `AIC_OP_CS0) | (operation_code_i == `AIC_OP_CS1);

  // ==========================================
  // Interpolation tracking state
  logic sync_q; // Synced circle in progress
  logic sync_d;

  // Synced circle flag follows each start
  always_comb begin
    sync_d = sync_q;
    if (start_i) begin
      sync_d = op_sync;
    end
  end

  // Register the synced circle flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // Data error detection on start and during a synced circle
  always_comb begin
    interp_err = 1'b0;
    if (start_i) begin
      if ((cls == AIC_OPC_LIN1) && (axes_n == 3'h1)) begin
        interp_err = 1'b1;
      end
      if (cls == AIC_OPC_CIRC) begin
        if (axes_n == 3'h1) begin
          interp_err = 1'b1;
        end
        if (circle_center_zero_i) begin
          interp_err = 1'b1;
        end
        if (axes_n >= 3'h3) begin
          interp_err = 1'b1;
        end
      end
      if ((cls == AIC_OPC_LIN2) && (interp_step_count_i == 32'h0000_0000)) begin
        interp_err = 1'b1;
      end
    end
    if (fourth_axis_fail_i && (sync_q || (start_i && op_sync))) begin
      interp_err = 1'b1;
    end
  end

  // ==========================================
  // Cause vectors, undefined bits held at zero
  assign err_set = {14'h0000, err_pulser_input_i, err_encoder_input_i,
                    err_position_range_i, err_pulser_overflow_i,
                    err_partner_axis_stop_i, interp_err, 1'b0,
                    err_slowdown_stop_i, err_emergency_i, err_shared_stop_i,
                    err_alarm_i, err_neg_limit_i, err_pos_limit_i,
                    err_cmp_stop_i};
  assign ev_set = {12'h000, ev_shared_start_i, ev_neg_pulser_change_i,
                   ev_pos_pulser_change_i, ev_slowdown_on_i,
                   ev_origin_latched_i, ev_counter_latched_i,
                   ev_counter_cleared_i, ev_cmp_match_i, 4'h0,
                   ev_cmp5_prereg_free_i, ev_second_prereg_free_i,
                   ev_next_start_i, ev_auto_stop_i};

  // ==========================================
  // Control registers
  aic_word_t env5_q; // Environment five
  aic_word_t env5_d;
  aic_word_t err_en_q; // Error enable mask
  aic_word_t err_en_d;
  aic_word_t ev_en_q; // Event enable mask
  aic_word_t ev_en_d;

  // Byte-lane writes to control registers
  always_comb begin
    env5_d = env5_q;
    err_en_d = err_en_q;
    ev_en_d = ev_en_q;
    if (req && wb_we_i) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          unique case (wb_adr_i)
            `AIC_OFF_ENV5: env5_d[8*b +: 8] = wb_dat_i[8*b +: 8];
            `AIC_OFF_ERR_EN: err_en_d[8*b +: 8] = wb_dat_i[8*b +: 8];
            `AIC_OFF_EV_EN: ev_en_d[8*b +: 8] = wb_dat_i[8*b +: 8];
            default: ; // Other offsets leave control alone
          endcase
        end
      end
    end
  end

  // Register control state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      env5_q <= `AIC_ENV5_RST;
      err_en_q <= `AIC_ERR_VALID; // Every defined cause enabled
      ev_en_q <= `AIC_EV_VALID; // Every defined cause enabled
    end else begin
      env5_q <= env5_d;
      err_en_q <= err_en_d & `AIC_ERR_VALID;
      ev_en_q <= ev_en_d & `AIC_EV_VALID;
    end
  end

  logic clr_mode; // Write-to-clear mode
  assign clr_mode = env5_q[`AIC_ENV5_CLR_MODE];
  assign cause_clear_mode_o = clr_mode;

  // ==========================================
  // Cause registers
  aic_word_t err_q; // Error stop cause
  aic_word_t err_d;
  aic_word_t ev_q; // Event cause
  aic_word_t ev_d;
  logic clr_err; // Clear error cause now
  logic clr_ev; // Clear event cause now

  // Clear source chosen by the mode bit
  always_comb begin
    if (clr_mode) begin
      clr_err = wr_err;
      clr_ev = wr_err;
    end else begin
      clr_err = rd_err;
      clr_ev = rd_ev;
    end
  end

  // Sticky bits: a new cause wins over a clear
  generate
    for (genvar i = 0; i < 32; i++) begin : g_bit
      always_comb begin
        err_d[i] = err_set[i] | (err_q[i] & ~clr_err);
        ev_d[i] = ev_set[i] | (ev_q[i] & ~clr_ev);
      end
    end
  endgenerate

  // Register causes, dropping undefined bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= 32'h0000_0000;
      ev_q <= 32'h0000_0000;
    end else begin
      err_q <= err_d & `AIC_ERR_VALID;
      ev_q <= ev_d & `AIC_EV_VALID;
    end
  end

  // ==========================================
  // Interrupt request and stop request
  logic irq_d;
  logic stop_d;

  // Request from enabled causes and stopping errors
  always_comb begin
    irq_d = |((err_d & `AIC_ERR_VALID & err_en_d) | (ev_d & `AIC_EV_VALID & ev_en_d));
    stop_d = |(err_set & `AIC_ERR_STOPS);
  end

  // Register the request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
      stop_request_o <= 1'b0;
    end else begin
      irq_o <= irq_d;
      stop_request_o <= stop_d;
    end
  end

  // ==========================================
  // Wishbone answer
  logic ack_d;
  aic_word_t dat_d;

  // Answer every request one cycle later
  always_comb begin
    ack_d = req;
    dat_d = 32'h0000_0000;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        `AIC_OFF_ERR: dat_d = err_q;
        `AIC_OFF_EV: dat_d = ev_q;
        `AIC_OFF_ENV5: dat_d = env5_q;
        `AIC_OFF_ERR_EN: dat_d = err_en_q;
        `AIC_OFF_EV_EN: dat_d = ev_en_q;
        default: dat_d = 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Register ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_err_sticky;
    (err_set != 32'h0000_0000) |=> ((err_q & $past(err_set)) == ($past(err_set) & `AIC_ERR_VALID));
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error cause lost");

  property p_ev_sticky;
    (ev_set != 32'h0000_0000) |=> ((ev_q & $past(ev_set)) == ($past(ev_set) & `AIC_EV_VALID));
  endproperty
  a_ev_sticky: assert property (p_ev_sticky) else $error("event cause lost");

  property p_mode1_hold;
    (clr_mode && !wr_err) |=> (($past(err_q) & ~err_q) == 32'h0000_0000);
  endproperty
  a_mode1_hold: assert property (p_mode1_hold) else $error("cause cleared without write");

  property p_mode1_wclr;
    (clr_mode && wr_err) |=> (ev_q == ($past(ev_set) & `AIC_EV_VALID));
  endproperty
  a_mode1_wclr: assert property (p_mode1_wclr) else $error("write did not clear events");

  property p_rd_clear;
    (!clr_mode && rd_err) |=> (err_q == ($past(err_set) & `AIC_ERR_VALID)) && wb_ack_o;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear errors");

  property p_reserved;
    ((err_q & ~`AIC_ERR_VALID) == 32'h0000_0000) && ((ev_q & ~`AIC_EV_VALID) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("undefined cause bit set");

  property p_irq;
    ##1 (irq_o == $past(|((err_d & err_en_d & `AIC_ERR_VALID) | (ev_d & ev_en_d & `AIC_EV_VALID))));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request wrong");

  property p_lin2_zero;
    (start_i && (cls == AIC_OPC_LIN2) && (interp_step_count_i == 32'h0000_0000))
      |=> err_q[`AIC_ERR_INTERP] && stop_request_o;
  endproperty
  a_lin2_zero: assert property (p_lin2_zero) else $error("zero step start not flagged");

  property p_one_axis;
    (start_i && (axes_n == 3'h1) && ((cls == AIC_OPC_LIN1) || (cls == AIC_OPC_CIRC)))
      |=> err_q[`AIC_ERR_INTERP];
  endproperty
  a_one_axis: assert property (p_one_axis) else $error("single axis start not flagged");

  property p_no_stop;
    ((err_set & `AIC_ERR_STOPS) == 32'h0000_0000) |=> !stop_request_o;
  endproperty
  a_no_stop: assert property (p_no_stop) else $error("stop without stopping cause");

  property p_ack;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");

endmodule

`default_nettype wire

/* File: aic_defines.svh */
// Offsets, field positions, reset values and masks for the cause block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH

// ==========================================
// Register byte offsets
`define AIC_ADR_W 8
`define AIC_OFF_ERR 8'h00
`define AIC_OFF_EV 8'h04
`define AIC_OFF_ENV5 8'h08
`define AIC_OFF_ERR_EN 8'h0C
`define AIC_OFF_EV_EN 8'h10

// ==========================================
// Field positions
`define AIC_ENV5_CLR_MODE 24
`define AIC_ERR_INTERP 12

// ==========================================
// Defined bits and reset values
`define AIC_ERR_VALID 32'h0003_F7FF
`define AIC_EV_VALID 32'h000F_FF0F
`define AIC_ERR_STOPS 32'h0000_F7FF
`define AIC_ENV5_RST 32'h0000_0000
`define AIC_EN_RST 32'hFFFF_FFFF

// ==========================================
// Operation codes of the interpolation modes
`define AIC_OP_L1A 8'h60
`define AIC_OP_L1B 8'h61
`define AIC_OP_L1C 8'h68
`define AIC_OP_L1D 8'h69
`define AIC_OP_L2A 8'h62
`define AIC_OP_L2B 8'h63
`define AIC_OP_L2C 8'h6A
`define AIC_OP_L2D 8'h6B
`define AIC_OP_C0 8'h64
`define AIC_OP_C1 8'h65
`define AIC_OP_CS0 8'h66
`define AIC_OP_CS1 8'h67
`define AIC_OP_C2 8'h6C
`define AIC_OP_C3 8'h6D

`endif

/* File: aic_pkg.sv */
// Types shared by the cause block.
// Assumes nothing of its surroundings.
package aic_pkg;

  // ==========================================
  // Interpolation mode class of an operation code
  typedef enum logic [1:0] {
    AIC_OPC_NONE = 2'h0,
    AIC_OPC_LIN1 = 2'h1,
    AIC_OPC_LIN2 = 2'h3,
    AIC_OPC_CIRC = 2'h2
  } aic_op_class_t;

  // Register word
  typedef logic [31:0] aic_word_t;

endpackage

/* File: aic_host_model.sv */
// Host CPU model: classic Wishbone single-cycle master for the cause block.
// Assumes a registered slave ack on the rising edge of clk_i.
`timescale 1ns/100ps
`default_nettype none

module aic_host_model (
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // ==========================================
  // Idle bus state
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'hFF;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // ==========================================
  // One transfer; request held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] s, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= wd;
    // Wait for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    // Release; released lines show the inverse of their last value
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_dat_o <= ~wd;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the cause registers.
// Assumes the host model above drives the Wishbone port.
`timescale 1ns/100ps
`include "aic_defines.svh"
`default_nettype none

module tb_top;
  import aic_pkg::*;
  // ==========================================
  // Signals
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [31:0] err_v = 32'h0, ev_v = 32'h0; // Cause pulses by bit position
  logic start_i = 1'b0, cz = 1'b0, fail = 1'b0;
  logic [3:0] axes = 4'h0;
  logic [7:0] opc = 8'h0;
  logic [31:0] stp = 32'h0;
  logic cyc, stb, we, ack, irq, stop, cmode, stop_seen;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  int num_errors = 0, n_compared = 0;

  always #12.5 clk_i = ~clk_i;
  // Sticky record of stop requests
  always @(posedge clk_i) if (stop === 1'b1) stop_seen <= 1'b1;

  aic_host_model u_host (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
    .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
  aic_cause_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .err_cmp_stop_i(err_v[4:0]), .err_pos_limit_i(err_v[5]), .err_neg_limit_i(err_v[6]),
    .err_alarm_i(err_v[7]), .err_shared_stop_i(err_v[8]), .err_emergency_i(err_v[9]),
    .err_slowdown_stop_i(err_v[10]), .err_partner_axis_stop_i(err_v[13]),
    .err_pulser_overflow_i(err_v[14]), .err_position_range_i(err_v[15]),
    .err_encoder_input_i(err_v[16]), .err_pulser_input_i(err_v[17]),
    .ev_auto_stop_i(ev_v[0]), .ev_next_start_i(ev_v[1]), .ev_second_prereg_free_i(ev_v[2]),
    .ev_cmp5_prereg_free_i(ev_v[3]), .ev_cmp_match_i(ev_v[12:8]), .ev_counter_cleared_i(ev_v[13]),
    .ev_counter_latched_i(ev_v[14]), .ev_origin_latched_i(ev_v[15]), .ev_slowdown_on_i(ev_v[16]),
    .ev_pos_pulser_change_i(ev_v[17]), .ev_neg_pulser_change_i(ev_v[18]),
    .ev_shared_start_i(ev_v[19]), .start_i(start_i), .start_axes_i(axes), .operation_code_i(opc),
    .circle_center_zero_i(cz), .interp_step_count_i(stp), .fourth_axis_fail_i(fail),
    .irq_o(irq), .stop_request_o(stop), .cause_clear_mode_o(cmode));

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected data error of a start
  function automatic logic iexp(logic [7:0] o, logic [3:0] ax, logic c, logic z, logic f);
    int n = $countones(ax);
    case (o)
      `AIC_OP_L1A, `AIC_OP_L1B, `AIC_OP_L1C, `AIC_OP_L1D: return n == 1;
      `AIC_OP_L2A, `AIC_OP_L2B, `AIC_OP_L2C, `AIC_OP_L2D: return z;
      `AIC_OP_C0, `AIC_OP_C1, `AIC_OP_C2, `AIC_OP_C3: return n == 1 || c || n >= 3;
      `AIC_OP_CS0, `AIC_OP_CS1: return n == 1 || c || n >= 3 || f;
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    u_host.xfer(1'b0, a, 32'h0, 4'hF, d);
    chk32("register read", e, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    u_host.xfer(1'b1, a, d, s, x);
  endtask
  // One-cycle cause pulse, then let the bit land
  task automatic pulse(input logic [31:0] e, input logic [31:0] v);
    @(posedge clk_i);
    err_v <= e;
    ev_v <= v;
    @(posedge clk_i);
    err_v <= 32'h0;
    ev_v <= 32'h0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #(25.0 * 20000);
    num_errors++;
    test_done();
  end

  // ==========================================
  // Main sequence
  logic [14:0] tbl [16] = '{ {8'h60,4'h1,3'b000}, {8'h61,4'h3,3'b000}, {8'h68,4'h2,3'b000},
    {8'h69,4'h6,3'b000}, {8'h62,4'h3,3'b010}, {8'h63,4'h3,3'b000}, {8'h6A,4'h5,3'b010},
    {8'h6B,4'h3,3'b000}, {8'h64,4'h1,3'b000}, {8'h65,4'h3,3'b100}, {8'h6C,4'h7,3'b000},
    {8'h6D,4'hF,3'b000}, {8'h66,4'h3,3'b001}, {8'h67,4'h3,3'b000}, {8'h64,4'h3,3'b000},
    {8'h65,4'h3,3'b001} };
  logic [31:0] s, e, v, xe, xv;
  initial begin
    stop_seen = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset state and unmapped place
    rd_chk(`AIC_OFF_ERR, 32'h0);
    rd_chk(`AIC_OFF_EV, 32'h0);
    rd_chk(`AIC_OFF_ENV5, `AIC_ENV5_RST);
    rd_chk(8'h40, 32'h0);
    chk1("irq", 1'b0, irq);
    $display("test reset done");
    // Every error source except bit 12 alone, then clear on read
    for (int i = 0; i < 32; i++) if (`AIC_ERR_VALID >> i & 1 && i != 12) begin
      stop_seen = 1'b0;
      pulse(32'h1 << i, 32'h0);
      chk1("irq", 1'b1, irq);
      rd_chk(`AIC_OFF_ERR, 32'h1 << i);
      rd_chk(`AIC_OFF_ERR, 32'h0);
      chk1("stop", i < 16, stop_seen);
      chk1("irq", 1'b0, irq);
    end
    for (int i = 0; i < 32; i++) if (`AIC_EV_VALID >> i & 1) begin
      pulse(32'h0, 32'h1 << i);
      wr(`AIC_OFF_EV, 32'hFFFF_FFFF, 4'hF);
      rd_chk(`AIC_OFF_EV, 32'h1 << i);
      rd_chk(`AIC_OFF_EV, 32'h0);
    end
    wr(`AIC_OFF_ERR, 32'hFFFF_FFFF, 4'hF);
    rd_chk(`AIC_OFF_ERR, 32'h0);
    $display("test single causes done");
    // Interpolation start checks
    foreach (tbl[k]) begin
      @(posedge clk_i);
      start_i <= 1'b1;
      opc <= tbl[k][14:7];
      axes <= tbl[k][6:3];
      cz <= tbl[k][2];
      stp <= tbl[k][1] ? 32'h0 : 32'h5;
      @(posedge clk_i);
      start_i <= 1'b0;
      fail <= tbl[k][0];
      @(posedge clk_i);
      fail <= 1'b0;
      rd_chk(`AIC_OFF_ERR, {19'h0, iexp(tbl[k][14:7], tbl[k][6:3], tbl[k][2], tbl[k][1], tbl[k][0]), 12'h0});
    end
    $display("test interpolation done");
    // Random mixes accumulate until read
    s = 32'h7d2b;
    xe = 32'h0;
    xv = 32'h0;
    for (int i = 1; i <= 24; i++) begin
      s = xs(s);
      e = s & `AIC_ERR_VALID & ~32'h1000;
      s = xs(s);
      v = s & `AIC_EV_VALID;
      xe |= e;
      xv |= v;
      pulse(e, v);
      if (i % 4 == 0) begin
        rd_chk(`AIC_OFF_ERR, xe);
        rd_chk(`AIC_OFF_EV, xv);
        xe = 32'h0;
        xv = 32'h0;
      end
    end
    $display("test random done");
    // Interrupt masking
    wr(`AIC_OFF_ERR_EN, 32'h0, 4'hF);
    wr(`AIC_OFF_EV_EN, 32'h0, 4'hF);
    pulse(32'h20, 32'h1);
    chk1("irq", 1'b0, irq);
    wr(`AIC_OFF_EV_EN, 32'h1, 4'h1);
    @(negedge clk_i);
    chk1("irq", 1'b1, irq);
    rd_chk(`AIC_OFF_EV, 32'h1);
    rd_chk(`AIC_OFF_ERR, 32'h20);
    wr(`AIC_OFF_ERR_EN, `AIC_EN_RST, 4'hF);
    $display("test masking done");
    // Clear mode 1: reads keep, only an error-register write clears
    wr(`AIC_OFF_ENV5, 32'h0100_0000, 4'h7);
    chk1("clear mode", 1'b0, cmode);
    wr(`AIC_OFF_ENV5, 32'h0100_0000, 4'h8);
    chk1("clear mode", 1'b1, cmode);
    pulse(32'h1, 32'h100);
    rd_chk(`AIC_OFF_ERR, 32'h1);
    rd_chk(`AIC_OFF_ERR, 32'h1);
    wr(`AIC_OFF_EV, 32'h0, 4'hF);
    rd_chk(`AIC_OFF_EV, 32'h100);
    wr(`AIC_OFF_ERR, 32'h0, 4'hF);
    rd_chk(`AIC_OFF_ERR, 32'h0);
    rd_chk(`AIC_OFF_EV, 32'h0);
    $display("test clear mode done");
    test_done();
  end
endmodule
`default_nettype wire
